// ==== rtl/mnq_pkg.sv ====
// Constants shared by both ends of the measurement notification queue.
// Assumes a 10 MHz clock on both ends and 16-bit shared-memory words.
package mnq_pkg;
  // ----------------------------------------
  // Shared-memory word offsets
  // ----------------------------------------
  localparam logic [15:0] OFF_CMD = 16'h0004;
  localparam logic [15:0] OFF_CSTAT = 16'h0006;
  localparam logic [15:0] OFF_FLAG = 16'h000C;
  localparam logic [15:0] OFF_QID = 16'h000E;
  localparam logic [15:0] OFF_CSIRQ = 16'h0010;
  localparam logic [7:0] CHAN_PAGE = 8'h01;
  // Interrupt word layout: enable, level, vector
  localparam int unsigned IRQ_EN_BIT = 15;
  localparam logic [15:0] FLAG_FULL = 16'hFFFF;
  localparam logic [7:0] CMD_ACK = 8'h01;
  localparam logic [15:0] REG_RST = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [15:0] POLL_GAP_RST = 16'h0064;
  // ----------------------------------------
  // Host APB register map
  // ----------------------------------------
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_ADDR = 8'h04;
  localparam logic [7:0] APB_WDATA = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
  localparam logic [7:0] APB_ISTAT = 8'h10;
  localparam logic [7:0] APB_IMASK = 8'h14;
  localparam logic [7:0] APB_QCTRL = 8'h18;
  localparam logic [7:0] APB_QRES = 8'h1C;
  localparam logic [7:0] APB_VRES = 8'h20;
  localparam int unsigned EV_ACC = 0;
  localparam int unsigned EV_QUE = 1;
  localparam int unsigned EV_VEC = 2;
endpackage

// ==== rtl/mnq_if.sv ====
// Shared-memory access and vectored interrupt path between the two ends.
// Assumes one clock; requests are held until ack, ack is a one-cycle pulse.
`timescale 1ns/1ps
interface mnq_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic irq_req;
  logic [2:0] irq_level;
  logic [7:0] irq_vector;
  logic irq_ack;
  modport dev (
    input req, we, addr, wdata, irq_ack,
    output rdata, ack, irq_req, irq_level, irq_vector
  );
  modport host (
    output req, we, addr, wdata, irq_ack,
    input rdata, ack, irq_req, irq_level, irq_vector
  );
endinterface

// ==== rtl/mnq_dev.sv ====
// Device end: shared words, channel blocks, interrupt and measurement queues.
// Assumes local logic reports completions and writes command status.
// How it works
// - Non-read completion raises channel's own level and vector; read uses command-status word
// - Ready or error code, same interrupt
// - Interrupts queued, released one per tick
// - Read commands: both statuses before interrupt
// - Interrupt unused: push id and status internally
// - Entries appended in completion order
// - Circular queue overwrites oldest, no report
// - Copy head to bytes, then flag ones
// - One entry per tick when flag zero
// - Flag accesses arbitrated; host spaces polls
// - Host prepares channel before writing command
// - Host polls command status until nonzero
// - Nonzero channel status marks completion
// - Status written with data, then interrupt
// - Host handler clears channel status
// - Host checks ones, copies, clears flag
// - Interrupting channels enter queue only on reads with command-status interrupt unused
`timescale 1ns/1ps
module mnq_dev #(
  parameter int unsigned NCH = 8,
  parameter int unsigned MQ_DEPTH = 16,
  parameter int unsigned IQ_DEPTH = 8,
  parameter int unsigned TICK_CYC = mnq_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host side
  mnq_if.dev bus,
  // Command hand-off to local logic
  output logic cmd_valid,
  output logic [15:0] cmd_code,
  input wire logic cs_we,
  input wire logic [15:0] cs_value,
  // Measurement completions
  input wire logic done_valid,
  input wire logic done_read,
  input wire logic [7:0] done_chan,
  input wire logic [7:0] done_status
);
  import mnq_pkg::*;

  localparam int unsigned CHW = $clog2(NCH);
  localparam int unsigned MQW = $clog2(MQ_DEPTH);
  localparam int unsigned IQW = $clog2(IQ_DEPTH);

  function automatic logic irq_usable(input logic [15:0] w);
    irq_usable = w[IRQ_EN_BIT] && (w[10:8] != 3'h0) && (w[7:0] != 8'h00);
  endfunction

  // ----------------------------------------
  // Service tick
  // ----------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = tick_cnt_q == 32'(TICK_CYC - 1);

  always_ff @(posedge clock) begin
    if (reset || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_q;
  logic arb_q;
  logic is_flag;
  logic acc;
  logic wr;
  logic in_chan;
  logic [5:0] ch_idx;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  assign is_flag = bus.addr == OFF_FLAG;
  assign acc = bus.req && !ack_q && (!is_flag || arb_q);
  assign wr = acc && bus.we;
  assign ch_idx = bus.addr[7:2];
  assign in_chan = (bus.addr[15:8] == CHAN_PAGE) && (32'(ch_idx) < NCH);
  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  // Flag sits in arbitrated memory: one extra wait state
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= 1'b0;
      arb_q <= 1'b0;
    end else begin
      ack_q <= acc;
      arb_q <= bus.req && is_flag && !ack_q && !arb_q;
    end
  end

  // ----------------------------------------
  // Channel control blocks
  // ----------------------------------------
  logic [15:0] chan_irq_q [NCH];
  logic [7:0] chan_stat_q [NCH];
  logic done_ok;
  logic [15:0] chan_w;
  assign done_ok = done_valid && (32'(done_chan) < NCH);
  assign chan_w = chan_irq_q[done_chan[CHW-1:0]];

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    always_ff @(posedge clock) begin
      if (reset) begin
        chan_irq_q[i] <= REG_RST;
      end else if (wr && in_chan && ch_idx == 6'(i) && !bus.addr[1]) begin
        chan_irq_q[i] <= bus.wdata;
      end
    end
    // Completion beats a host clear in the same cycle
    always_ff @(posedge clock) begin
      if (reset) begin
        chan_stat_q[i] <= REG_RST[7:0];
      end else if (done_ok && done_chan == 8'(i)) begin
        chan_stat_q[i] <= done_status;
      end else if (wr && in_chan && ch_idx == 6'(i) && bus.addr[1]) begin
        chan_stat_q[i] <= bus.wdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Command words
  // ----------------------------------------
  logic [15:0] cmd_q;
  logic [15:0] cstat_q;
  logic [15:0] csirq_q;
  logic cmd_valid_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_code = cmd_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_q <= REG_RST;
      cmd_valid_q <= 1'b0;
      csirq_q <= REG_RST;
    end else begin
      cmd_valid_q <= wr && bus.addr == OFF_CMD;
      if (wr && bus.addr == OFF_CMD) begin
        cmd_q <= bus.wdata;
      end
      if (wr && bus.addr == OFF_CSIRQ) begin
        csirq_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cstat_q <= REG_RST;
    end else if (done_ok && done_read) begin
      cstat_q <= {8'h00, done_status};
    end else if (cs_we) begin
      cstat_q <= cs_value;
    end
  end

  // ----------------------------------------
  // Routing of a completion
  // ----------------------------------------
  logic use_irq;
  logic push_irq;
  logic push_mq;
  logic [10:0] irq_word;
  assign use_irq = done_read ? irq_usable(csirq_q) : irq_usable(chan_w);
  assign push_irq = done_ok && use_irq;
  assign push_mq = done_ok && !use_irq;
  assign irq_word = done_read ? csirq_q[10:0] : chan_w[10:0];

  // ----------------------------------------
  // Interrupt queue
  // ----------------------------------------
  logic [10:0] iq_mem [IQ_DEPTH];
  logic [IQW-1:0] iq_wr_q;
  logic [IQW-1:0] iq_rd_q;
  logic [IQW:0] iq_cnt_q;
  logic iq_push;
  logic iq_pop;
  logic irq_req_q;
  logic [2:0] irq_lvl_q;
  logic [7:0] irq_vec_q;
  // Full queue drops the newest; tick pacing bounds the loss
  assign iq_push = push_irq && iq_cnt_q != (IQW+1)'(IQ_DEPTH);
  assign iq_pop = tick && !irq_req_q && iq_cnt_q != '0;
  assign bus.irq_req = irq_req_q;
  assign bus.irq_level = irq_lvl_q;
  assign bus.irq_vector = irq_vec_q;

  always_ff @(posedge clock) begin
    if (iq_push) begin
      iq_mem[iq_wr_q] <= irq_word;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      iq_wr_q <= '0;
      iq_rd_q <= '0;
      iq_cnt_q <= '0;
    end else begin
      if (iq_push) begin
        iq_wr_q <= (iq_wr_q == IQW'(IQ_DEPTH - 1)) ? '0 : iq_wr_q + 1'b1;
      end
      if (iq_pop) begin
        iq_rd_q <= (iq_rd_q == IQW'(IQ_DEPTH - 1)) ? '0 : iq_rd_q + 1'b1;
      end
      if (iq_push && !iq_pop) begin
        iq_cnt_q <= iq_cnt_q + 1'b1;
      end else if (iq_pop && !iq_push) begin
        iq_cnt_q <= iq_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_req_q <= 1'b0;
      irq_lvl_q <= 3'h0;
      irq_vec_q <= 8'h00;
    end else if (iq_pop) begin
      irq_req_q <= 1'b1;
      irq_lvl_q <= iq_mem[iq_rd_q][10:8];
      irq_vec_q <= iq_mem[iq_rd_q][7:0];
    end else if (bus.irq_ack) begin
      irq_req_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Measurement queue
  // ----------------------------------------
  logic [15:0] mq_mem [MQ_DEPTH];
  logic [MQW-1:0] mq_wr_q;
  logic [MQW-1:0] mq_rd_q;
  logic [MQW:0] mq_cnt_q;
  logic mq_full;
  logic mq_pop;
  logic [15:0] flag_q;
  logic [7:0] qid_q;
  logic [7:0] qst_q;
  assign mq_full = mq_cnt_q == (MQW+1)'(MQ_DEPTH);
  assign mq_pop = tick && flag_q == 16'h0000 && mq_cnt_q != '0;

  always_ff @(posedge clock) begin
    if (push_mq) begin
      mq_mem[mq_wr_q] <= {done_chan, done_status};
    end
  end

  // Full push moves the read side too: oldest entry silently lost
  always_ff @(posedge clock) begin
    if (reset) begin
      mq_wr_q <= '0;
      mq_rd_q <= '0;
      mq_cnt_q <= '0;
    end else begin
      if (push_mq) begin
        mq_wr_q <= (mq_wr_q == MQW'(MQ_DEPTH - 1)) ? '0 : mq_wr_q + 1'b1;
      end
      if (mq_pop || (push_mq && mq_full)) begin
        mq_rd_q <= (mq_rd_q == MQW'(MQ_DEPTH - 1)) ? '0 : mq_rd_q + 1'b1;
      end
      if (push_mq && !mq_pop && !mq_full) begin
        mq_cnt_q <= mq_cnt_q + 1'b1;
      end else if (mq_pop && !push_mq) begin
        mq_cnt_q <= mq_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      qid_q <= 8'h00;
      qst_q <= 8'h00;
    end else if (mq_pop) begin
      {qid_q, qst_q} <= mq_mem[mq_rd_q];
    end
  end

  // Device set beats a host clear landing in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      flag_q <= REG_RST;
    end else if (mq_pop) begin
      flag_q <= FLAG_FULL;
    end else if (wr && is_flag) begin
      flag_q <= bus.wdata;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_d = 16'h0000;
    if (bus.addr == OFF_CMD) begin
      rdata_d = cmd_q;
    end else if (bus.addr == OFF_CSTAT) begin
      rdata_d = cstat_q;
    end else if (is_flag) begin
      rdata_d = flag_q;
    end else if (bus.addr == OFF_QID) begin
      rdata_d = {qid_q, qst_q};
    end else if (bus.addr == OFF_CSIRQ) begin
      rdata_d = csirq_q;
    end else if (in_chan) begin
      rdata_d = bus.addr[1] ? {8'h00, chan_stat_q[ch_idx[CHW-1:0]]}
                            : chan_irq_q[ch_idx[CHW-1:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (acc && !bus.we) begin
      rdata_q <= rdata_d;
    end
  end
endmodule

// ==== rtl/mnq_host.sv ====
// Host end: APB-driven access engine, queue poller, vectored interrupt taker.
// Assumes an APB master on the user side and the device on mnq_if.
`timescale 1ns/1ps
module mnq_host (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Device side
  mnq_if.host bus
);
  import mnq_pkg::*;

  typedef enum {HS_IDLE, HS_WAIT, HS_NEXT} mnq_hst_t;
  typedef enum {OP_SW, OP_FLAG, OP_QID, OP_CLR} mnq_op_t;

  mnq_hst_t st_q;
  mnq_op_t op_q;
  logic apb_wr;
  logic [15:0] acc_addr_q;
  logic [15:0] acc_wdata_q;
  logic [15:0] acc_rdata_q;
  logic acc_we_q;
  logic go_q;
  logic qen_q;
  logic [15:0] gap_q;
  logic [15:0] gap_cnt_q;
  logic [15:0] qres_q;
  logic [10:0] vres_q;
  logic [2:0] ist_q;
  logic [2:0] imask_q;
  logic [2:0] ev;
  logic irq_ack_q;
  logic take_sw;
  logic take_poll;
  logic done;

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(ist_q & imask_q);
  assign take_sw = st_q == HS_IDLE && go_q;
  assign take_poll = st_q == HS_IDLE && !go_q && qen_q && gap_cnt_q == 16'h0000;
  assign done = st_q == HS_WAIT && bus.ack;
  assign bus.irq_ack = irq_ack_q;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      acc_addr_q <= REG_RST;
      acc_wdata_q <= REG_RST;
      acc_we_q <= 1'b0;
      go_q <= 1'b0;
      qen_q <= 1'b0;
      gap_q <= POLL_GAP_RST;
      imask_q <= 3'h0;
    end else begin
      if (take_sw) begin
        go_q <= 1'b0;
      end
      if (apb_wr && paddr == APB_CTRL) begin
        go_q <= pwdata[0];
        acc_we_q <= pwdata[1];
      end
      if (apb_wr && paddr == APB_ADDR) begin
        acc_addr_q <= pwdata[15:0];
      end
      if (apb_wr && paddr == APB_WDATA) begin
        acc_wdata_q <= pwdata[15:0];
      end
      if (apb_wr && paddr == APB_QCTRL) begin
        qen_q <= pwdata[16];
        gap_q <= pwdata[15:0];
      end
      if (apb_wr && paddr == APB_IMASK) begin
        imask_q <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Access engine and queue poller
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= HS_IDLE;
      op_q <= OP_SW;
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.addr <= 16'h0000;
      bus.wdata <= 16'h0000;
    end else begin
      unique case (st_q)
        HS_IDLE: begin
          if (take_sw) begin
            op_q <= OP_SW;
            bus.req <= 1'b1;
            bus.we <= acc_we_q;
            bus.addr <= acc_addr_q;
            bus.wdata <= acc_wdata_q;
            st_q <= HS_WAIT;
          end else if (take_poll) begin
            op_q <= OP_FLAG;
            bus.req <= 1'b1;
            bus.we <= 1'b0;
            bus.addr <= OFF_FLAG;
            st_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (bus.ack) begin
            bus.req <= 1'b0;
            st_q <= HS_IDLE;
            if (op_q == OP_FLAG && bus.rdata == FLAG_FULL) begin
              op_q <= OP_QID;
              st_q <= HS_NEXT;
            end else if (op_q == OP_QID) begin
              op_q <= OP_CLR;
              st_q <= HS_NEXT;
            end
          end
        end
        HS_NEXT: begin
          bus.req <= 1'b1;
          bus.we <= op_q == OP_CLR;
          bus.addr <= (op_q == OP_CLR) ? OFF_FLAG : OFF_QID;
          bus.wdata <= 16'h0000;
          st_q <= HS_WAIT;
        end
      endcase
    end
  end

  // Poll spacing restarts after each finished poll
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_cnt_q <= POLL_GAP_RST;
    end else if (done && op_q != OP_SW) begin
      gap_cnt_q <= gap_q;
    end else if (gap_cnt_q != 16'h0000) begin
      gap_cnt_q <= gap_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      acc_rdata_q <= REG_RST;
      qres_q <= REG_RST;
    end else if (done && op_q == OP_SW) begin
      acc_rdata_q <= bus.rdata;
    end else if (done && op_q == OP_QID) begin
      qres_q <= bus.rdata;
    end
  end

  // ----------------------------------------
  // Vectored interrupts and event status
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_ack_q <= 1'b0;
      vres_q <= 11'h000;
    end else begin
      irq_ack_q <= bus.irq_req && !irq_ack_q;
      if (bus.irq_req && !irq_ack_q) begin
        vres_q <= {bus.irq_level, bus.irq_vector};
      end
    end
  end

  always_comb begin
    ev = 3'h0;
    ev[EV_ACC] = done && op_q == OP_SW;
    ev[EV_QUE] = done && op_q == OP_QID;
    ev[EV_VEC] = bus.irq_req && !irq_ack_q;
  end

  // New event wins over a write-one clear
  always_ff @(posedge clock) begin
    if (reset) begin
      ist_q <= 3'h0;
    end else if (apb_wr && paddr == APB_ISTAT) begin
      ist_q <= (ist_q & ~pwdata[2:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  // ----------------------------------------
  // APB read data, captured in the setup cycle
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        APB_CTRL: prdata <= {29'h0, st_q != HS_IDLE, acc_we_q, go_q};
        APB_ADDR: prdata <= {16'h0000, acc_addr_q};
        APB_WDATA: prdata <= {16'h0000, acc_wdata_q};
        APB_RDATA: prdata <= {16'h0000, acc_rdata_q};
        APB_ISTAT: prdata <= {29'h0, ist_q};
        APB_IMASK: prdata <= {29'h0, imask_q};
        APB_QCTRL: prdata <= {15'h0000, qen_q, gap_q};
        APB_QRES: prdata <= {16'h0000, qres_q};
        APB_VRES: prdata <= {21'h000000, vres_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== bench/mnq_checker.sv ====
// Concurrent checks on the shared bus and interrupt path.
// Assumes one clock and sync active-high reset.
`timescale 1ns/1ps
module mnq_checker #(
  parameter int unsigned TICK_CYC = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Shared bus
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  // Vectored interrupt
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic [7:0] irq_vector,
  input wire logic irq_ack
);
  import mnq_pkg::*;
  logic [15:0] gap_q;
  logic irq_prev_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // Cycles since last irq rise; saturates
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_q <= 16'hFFFF;
      irq_prev_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_req;
      if (irq_req && !irq_prev_q) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hFFFF) begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Bus answer sequences
  // ----------------------------------------
  sequence s_flag_start;
    $rose(req) && addr == OFF_FLAG;
  endsequence
  sequence s_plain_start;
    $rose(req) && addr != OFF_FLAG;
  endsequence
  sequence s_flag_answer;
    !ack ##1 ack;
  endsequence
  a_flag_wait: assert property (s_flag_start |=> s_flag_answer)
    else $error("flag answer late");
  a_plain_answer: assert property (s_plain_start |=> ack)
    else $error("plain answer late");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack too long");
  a_ack_with_req: assert property (ack |-> req)
    else $error("ack without request");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
    && $stable(wdata))
    else $error("request moved");
  // ----------------------------------------
  // Interrupt delivery
  // ----------------------------------------
  a_irq_spacing: assert property ($rose(irq_req) |-> gap_q >= 16'(TICK_CYC - 1))
    else $error("irq too close");
  a_irq_fields: assert property (irq_req |-> irq_level != 3'h0 && irq_vector != 8'h00)
    else $error("irq fields zero");
  a_irq_stable: assert property (irq_req && $past(irq_req) |->
    $stable(irq_level) && $stable(irq_vector))
    else $error("irq fields moved");
  a_irq_taken: assert property ($rose(irq_req) |=> ##[0:1] irq_ack)
    else $error("vector not taken");
  a_irq_clear: assert property (irq_ack |=> !irq_req && !irq_ack)
    else $error("irq not dropped");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: APB software drives host end against device end.
// Assumes a short tick and a small queue for quick overflow.
`timescale 1ns/1ps
module testbench;
  import mnq_pkg::*;
  localparam int unsigned TCK = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic cs_we = 1'b0;
  logic [15:0] cs_value = 16'h0000;
  logic done_valid = 1'b0;
  logic done_read = 1'b0;
  logic [7:0] done_chan = 8'h00;
  logic [7:0] done_status = 8'h00;
  logic cmd_valid;
  logic [15:0] cmd_code;
  logic [15:0] cmd_seen;
  logic [15:0] cmd_w;
  logic [15:0] d16;
  logic [31:0] rd;
  logic [31:0] seed = 32'd86;
  logic [7:0] st [7];
  logic [7:0] id [7];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int j;
  mnq_if link();
  mnq_dev #(.NCH(8), .MQ_DEPTH(4), .IQ_DEPTH(8), .TICK_CYC(TCK)) mnq_dev_i (
    .clock(clock), .reset(reset), .bus(link), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cs_we(cs_we), .cs_value(cs_value), .done_valid(done_valid), .done_read(done_read),
    .done_chan(done_chan), .done_status(done_status));
  mnq_host mnq_host_i (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .bus(link));
  mnq_checker #(.TICK_CYC(TCK)) mnq_checker_i (
    .clock(clock), .reset(reset), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .irq_req(link.irq_req),
    .irq_level(link.irq_level), .irq_vector(link.irq_vector), .irq_ack(link.irq_ack));
  initial begin
    forever #50 clock = ~clock;
  end
  // Latch the one-cycle command strobe
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) begin
      cmd_seen <= cmd_code;
    end
    if (cycles == 40000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [15:0] chan_word(input int ch, input int off);
    return {CHAN_PAGE, 8'(ch * 4 + off)};
  endfunction
  function logic [15:0] irq_word(input logic [2:0] l, input logic [7:0] v);
    return {1'b1, 4'h0, l, v};
  endfunction
  function logic [31:0] vres(input logic [2:0] l, input logic [7:0] v);
    return {21'h0, l, v};
  endfunction
  task complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0, "pslverr");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wait_istat(input int b, input int lim);
    for (int n = 0; n == 0 || (rd[b] !== 1'b1 && n < lim); n++) apb(1'b0, APB_ISTAT, 32'h0);
    chk(rd[b], 32'h1, "status event");
  endtask
  // One shared word access via the host engine
  task dacc(input logic wr, input logic [15:0] a, input logic [15:0] wd);
    apb(1'b1, APB_ADDR, {16'h0, a});
    apb(1'b1, APB_WDATA, {16'h0, wd});
    apb(1'b1, APB_CTRL, {30'h0, wr, 1'b1});
    wait_istat(EV_ACC, 40);
    apb(1'b1, APB_ISTAT, 32'h1);
    apb(1'b0, APB_RDATA, 32'h0);
    d16 = rd[15:0];
  endtask
  task done(input logic r, input logic [7:0] c, input logic [7:0] s);
    done_valid <= 1'b1;
    done_read <= r;
    done_chan <= c;
    done_status <= s;
    @(posedge clock);
  endtask
  task wait_irq();
    for (int n = 0; irq !== 1'b1 && n < 300; n++) @(posedge clock);
    chk({31'h0, irq}, 32'h1, "irq raised");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b0, APB_QCTRL, 32'h0);
    chk(rd, {16'h0, POLL_GAP_RST}, "qctrl reset");
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0, "unmapped apb");
    cmd_w = {rnd8(), rnd8()};
    dacc(1'b1, OFF_CMD, cmd_w);
    chk({16'h0, cmd_seen}, {16'h0, cmd_w}, "command code");
    cs_we <= 1'b1;
    cs_value <= {8'h00, CMD_ACK};
    @(posedge clock);
    cs_we <= 1'b0;
    dacc(1'b1, OFF_CSTAT, 16'hBEEF);
    dacc(1'b0, OFF_CSTAT, 16'h0000);
    chk({16'h0, d16}, {24'h0, CMD_ACK}, "command status");
    dacc(1'b0, 16'h0002, 16'h0000);
    chk({16'h0, d16}, 32'h0, "unmapped word");
    // Interrupting channel: success, then two masked errors
    apb(1'b1, APB_IMASK, 32'h4);
    dacc(1'b1, chan_word(1, 0), irq_word(3'h3, 8'h5A));
    st[0] = rnd8() | 8'h01;
    done(1'b0, 8'h01, st[0]);
    done_valid <= 1'b0;
    wait_irq();
    apb(1'b0, APB_VRES, 32'h0);
    chk(rd, vres(3'h3, 8'h5A), "channel vector");
    dacc(1'b0, chan_word(1, 2), 16'h0000);
    chk({16'h0, d16}, {24'h0, st[0]}, "channel status");
    dacc(1'b1, chan_word(1, 2), 16'h0000);
    apb(1'b1, APB_ISTAT, 32'h4);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, APB_IMASK, 32'h0);
    done(1'b0, 8'h01, 8'hE1);
    done(1'b0, 8'h01, 8'hE2);
    done_valid <= 1'b0;
    repeat (3 * TCK) @(posedge clock);
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b0, APB_ISTAT, 32'h0);
    chk(rd & 32'h4, 32'h4, "error irq");
    dacc(1'b0, chan_word(1, 2), 16'h0000);
    chk({16'h0, d16}, 32'hE2, "error status");
    dacc(1'b0, OFF_FLAG, 16'h0000);
    chk({16'h0, d16}, 32'h0, "no queue entry");
    // Discrete read via command-status interrupt
    apb(1'b1, APB_ISTAT, 32'h4);
    apb(1'b1, APB_IMASK, 32'h4);
    dacc(1'b1, OFF_CSIRQ, irq_word(3'h5, 8'h33));
    st[1] = rnd8() | 8'h01;
    done(1'b1, 8'h03, st[1]);
    done_valid <= 1'b0;
    wait_irq();
    apb(1'b0, APB_VRES, 32'h0);
    chk(rd, vres(3'h5, 8'h33), "cmd vector");
    dacc(1'b0, OFF_CSTAT, 16'h0000);
    chk({16'h0, d16}, {24'h0, st[1]}, "read cmd status");
    dacc(1'b0, chan_word(3, 2), 16'h0000);
    chk({16'h0, d16}, {24'h0, st[1]}, "read chan status");
    apb(1'b1, APB_IMASK, 32'h0);
    // Queue: one parked entry, then overflow depth four
    for (int i = 0; i < 7; i++) begin
      id[i] = (i % 2 == 1) ? 8'h04 : 8'h02;
      st[i] = rnd8() | 8'h01;
    end
    done(1'b0, id[0], st[0]);
    done_valid <= 1'b0;
    repeat (2 * TCK) @(posedge clock);
    dacc(1'b0, OFF_FLAG, 16'h0000);
    chk({16'h0, d16}, {16'h0, FLAG_FULL}, "flag set");
    dacc(1'b0, OFF_QID, 16'h0000);
    chk({16'h0, d16}, {16'h0, id[0], st[0]}, "head entry");
    for (int i = 1; i < 7; i++) begin
      done(1'b0, id[i], st[i]);
    end
    done_valid <= 1'b0;
    // Spaced polls leave each entry until read
    apb(1'b1, APB_QCTRL, {15'h0, 1'b1, 16'd40});
    for (int k = 0; k < 5; k++) begin
      j = (k == 0) ? 0 : k + 2;
      wait_istat(EV_QUE, 200);
      apb(1'b0, APB_QRES, 32'h0);
      chk(rd, {16'h0, id[j], st[j]}, "queued entry");
      apb(1'b1, APB_ISTAT, 32'h2);
    end
    repeat (150) @(posedge clock);
    apb(1'b0, APB_ISTAT, 32'h0);
    chk(rd & 32'h2, 32'h0, "queue drained");
    complete_run();
  end
endmodule
